// File: mlpr_map.vh
`ifndef MLPR_MAP_VH
`define MLPR_MAP_VH
// ----------------------------------------------------------------------------
// readout geometry
// ----------------------------------------------------------------------------
`define MLPR_NUM_LINKS 16
`define MLPR_WORD_W 12
`define MLPR_BURST_LAST 7'h7f
`define MLPR_ROWS_DEFAULT 12'h440
// ----------------------------------------------------------------------------
// multiplex select codes
// ----------------------------------------------------------------------------
`define MLPR_MUX_16 2'h0
`define MLPR_MUX_8 2'h1
`define MLPR_MUX_4 2'h2
`define MLPR_MUX_2 2'h3
// last burst index of a row, which is also the channel group mask
`define MLPR_LAST_16 3'h0
`define MLPR_LAST_8 3'h1
`define MLPR_LAST_4 3'h3
`define MLPR_LAST_2 3'h7
// ----------------------------------------------------------------------------
// control word
// ----------------------------------------------------------------------------
`define MLPR_CW_PIXEL 0
`define MLPR_CW_ROW 1
`define MLPR_CW_FRAME 2
`define MLPR_CW_SLOT 3
`define MLPR_CW_ROWHEAD 4
`define MLPR_CW_IDLE 12'h200
// ----------------------------------------------------------------------------
// serial word lengths
// ----------------------------------------------------------------------------
`define MLPR_BITS_TEN 4'h9
`define MLPR_BITS_TWELVE 4'hb
`define MLPR_MASK_TEN 12'h3ff
`define MLPR_MASK_TWELVE 12'hfff
// ----------------------------------------------------------------------------
// sequencer states
// ----------------------------------------------------------------------------
`define MLPR_ST_IDLE 2'h0
`define MLPR_ST_SLOT 2'h1
`define MLPR_ST_BURST 2'h2
`endif

// File: mlpr_readout.v
// Summary of operation
// - drive sixteen data links, one control link and one forwarded clock link.
// - forwarded clock is ddr, toggling once per serial bit.
// - control link sends status words of pixel width in lockstep with data.
// - words go lsb first, first_serial_bit during forwarded clock high phase.
// - bit time is a tenth or twelfth of the pixel clock period.
// - readout in 128-pixel bursts, one pixel per pixel clock period.
// - one overhead pixel period is inserted before every burst.
// - sixteen-link mode sends a whole 2048-pixel row in one burst.
// - eight, four, two links take 2, 4, 8 bursts plus slots per row.
// - twelve-bit mode forces four links unless two links are selected.
// - eight-link mode uses odd links only; even links may be disabled.
// - four-link mode uses links 1, 5, 9, 13, four bursts each.
// - four-link mode maps pixel quarters to links 1, 5, 9, 13 ascending.
// - two-link mode uses links 1 and 9, eight bursts per row.
// - rows per frame programmable, 1088 by default.
// - control bits 0..2 flag pixel, row, frame valid; bits 8..11 are 0100.
// - data links send training word whenever no valid pixel is sent.
// - inactive links copy the active link serving their group.
// - idle control word is 512, only bit 9 set.
`timescale 1ns/1ps
`default_nettype none
`include "mlpr_map.vh"

module mlpr_readout #(
  parameter NLINK = `MLPR_NUM_LINKS,
  parameter WW = `MLPR_WORD_W,
  parameter ROW_W = 12
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_pixel_clk,
  input wire i_bit_strobe,
  input wire i_twelve_bit,
  input wire [1:0] i_mux_sel,
  input wire [ROW_W-1:0] i_row_count,
  input wire [WW-1:0] i_train_word,
  input wire i_frame_req,
  input wire [NLINK*WW-1:0] i_src_words,
  output reg o_rd_valid,
  output reg [2:0] o_rd_burst,
  output reg [6:0] o_rd_index,
  output reg [ROW_W-1:0] o_rd_row,
  output reg [NLINK-1:0] o_link_enable,
  output reg [NLINK-1:0] o_data_bits,
  output reg o_ctrl_bit,
  output reg o_forwarded_ddr_clock
);

  // ----------------------------------------------------------------------------
  // pixel clock synchroniser and edge finder
  // ----------------------------------------------------------------------------
  reg pclk_s1_q;
  reg pclk_s2_q;
  reg pclk_s3_q;
  reg pclk_lvl_q;
  wire pclk_agree;
  wire tick;

  // three stages; a level change is accepted once stages two and three agree
  // stages reset high so a pin already high at release gives no false rising edge
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pclk_s1_q <= 1'b1;
      pclk_s2_q <= 1'b1;
      pclk_s3_q <= 1'b1;
      pclk_lvl_q <= 1'b1;
    end else if (i_ce) begin
      pclk_s1_q <= i_pixel_clk;
      pclk_s2_q <= pclk_s1_q;
      pclk_s3_q <= pclk_s2_q;
      if (pclk_agree) begin
        pclk_lvl_q <= pclk_s3_q;
      end
    end
  end

  assign pclk_agree = (pclk_s2_q == pclk_s3_q);
  // one pixel period begins at each accepted rising edge
  assign tick = i_ce & pclk_agree & pclk_s3_q & ~pclk_lvl_q;

  // ----------------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------------
  reg [1:0] mux_eff;
  reg [2:0] last_sel;

  // twelve-bit mode falls back to four links unless two are asked for
  always @* begin
    mux_eff = i_mux_sel;
    if (i_twelve_bit && (i_mux_sel != `MLPR_MUX_2)) begin
      mux_eff = `MLPR_MUX_4;
    end
    case (mux_eff)
      `MLPR_MUX_16: last_sel = `MLPR_LAST_16;
      `MLPR_MUX_8: last_sel = `MLPR_LAST_8;
      `MLPR_MUX_4: last_sel = `MLPR_LAST_4;
      default: last_sel = `MLPR_LAST_2;
    endcase
  end

  // ----------------------------------------------------------------------------
  // row and burst sequencer
  // ----------------------------------------------------------------------------
  reg [1:0] state_q;
  reg req_q;
  reg [2:0] last_q;
  reg twelve_q;
  reg [ROW_W-1:0] rows_q;
  wire [2:0] burst_next;
  wire [ROW_W-1:0] row_next;

  assign burst_next = o_rd_burst + 3'h1;
  assign row_next = o_rd_row + {{(ROW_W-1){1'b0}}, 1'b1};

  // mode and row count are frozen at frame start so a frame stays coherent
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= `MLPR_ST_IDLE;
      req_q <= 1'b0;
      last_q <= `MLPR_LAST_16;
      twelve_q <= 1'b0;
      rows_q <= `MLPR_ROWS_DEFAULT;
      o_rd_valid <= 1'b0;
      o_rd_burst <= 3'h0;
      o_rd_index <= 7'h00;
      o_rd_row <= {ROW_W{1'b0}};
    end else if (i_ce) begin
      if (i_frame_req) begin
        req_q <= 1'b1;
      end else if (tick && (state_q == `MLPR_ST_IDLE)) begin
        req_q <= 1'b0;
      end
      if (tick) begin
        case (state_q)
          `MLPR_ST_IDLE: begin
            if (req_q) begin
              state_q <= `MLPR_ST_SLOT;
              last_q <= last_sel;
              twelve_q <= i_twelve_bit;
              rows_q <= i_row_count;
              o_rd_burst <= 3'h0;
              o_rd_row <= {ROW_W{1'b0}};
            end
          end
          `MLPR_ST_SLOT: begin
            // one overhead period then the burst itself
            state_q <= `MLPR_ST_BURST;
            o_rd_valid <= 1'b1;
            o_rd_index <= 7'h00;
          end
          `MLPR_ST_BURST: begin
            if (o_rd_index == `MLPR_BURST_LAST) begin
              o_rd_valid <= 1'b0;
              if (o_rd_burst == last_q) begin
                // last burst of the row: next row or end of frame
                o_rd_burst <= 3'h0;
                if (row_next == rows_q) begin
                  state_q <= `MLPR_ST_IDLE;
                end else begin
                  state_q <= `MLPR_ST_SLOT;
                  o_rd_row <= row_next;
                end
              end else begin
                state_q <= `MLPR_ST_SLOT;
                o_rd_burst <= burst_next;
              end
            end else begin
              o_rd_index <= o_rd_index + 7'h01;
            end
          end
          default: begin
            state_q <= `MLPR_ST_IDLE;
            o_rd_valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // control word for the period being loaded
  // ----------------------------------------------------------------------------
  reg [WW-1:0] ctrl_word;
  reg [WW-1:0] word_mask;

  always @* begin
    ctrl_word = `MLPR_CW_IDLE;
    if (state_q == `MLPR_ST_SLOT) begin
      ctrl_word[`MLPR_CW_ROW] = 1'b1;
      ctrl_word[`MLPR_CW_FRAME] = 1'b1;
      ctrl_word[`MLPR_CW_SLOT] = 1'b1;
      ctrl_word[`MLPR_CW_ROWHEAD] = (o_rd_burst == 3'h0);
    end else if (state_q == `MLPR_ST_BURST) begin
      ctrl_word[`MLPR_CW_PIXEL] = 1'b1;
      ctrl_word[`MLPR_CW_ROW] = 1'b1;
      ctrl_word[`MLPR_CW_FRAME] = 1'b1;
    end
    word_mask = twelve_q ? `MLPR_MASK_TWELVE : `MLPR_MASK_TEN;
  end

  // ----------------------------------------------------------------------------
  // serialiser bit counter and forwarded clock
  // ----------------------------------------------------------------------------
  reg [3:0] bit_cnt_q;
  reg [WW-1:0] ctrl_sh_q;
  wire [3:0] bit_last;
  wire shift;

  assign bit_last = twelve_q ? `MLPR_BITS_TWELVE : `MLPR_BITS_TEN;
  // bits stop after the last of a word until the next pixel period loads
  assign shift = i_ce & i_bit_strobe & ~tick & (bit_cnt_q < bit_last);

  // the clock goes high with the first bit of each word and toggles per bit
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_q <= `MLPR_BITS_TWELVE; // spent, so no phantom word before the first tick
      ctrl_sh_q <= {WW{1'b0}};
      o_ctrl_bit <= 1'b0;
      o_forwarded_ddr_clock <= 1'b0;
    end else if (tick) begin
      bit_cnt_q <= 4'h0;
      o_forwarded_ddr_clock <= 1'b1;
      o_ctrl_bit <= ctrl_word[0];
      ctrl_sh_q <= {1'b0, ctrl_word[WW-1:1]};
    end else if (shift) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      o_forwarded_ddr_clock <= ~o_forwarded_ddr_clock;
      o_ctrl_bit <= ctrl_sh_q[0];
      ctrl_sh_q <= {1'b0, ctrl_sh_q[WW-1:1]};
    end
  end

  // ----------------------------------------------------------------------------
  // data links
  // ----------------------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < NLINK; k = k + 1) begin : g_link
      reg [WW-1:0] sh_q;
      reg [WW-1:0] word;
      wire [4:0] serving;
      localparam [4:0] LINK_IDX = k;

      // group leader of this output under the frozen multiplex mode
      assign serving = LINK_IDX & ~{2'h0, last_q};

      always @* begin
        word = i_train_word & word_mask;
        if (state_q == `MLPR_ST_BURST) begin
          word = i_src_words[serving*WW +: WW] & word_mask;
        end
      end

      always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          sh_q <= {WW{1'b0}};
          o_data_bits[k] <= 1'b0;
          o_link_enable[k] <= 1'b1;
        end else if (tick) begin
          o_data_bits[k] <= word[0];
          sh_q <= {1'b0, word[WW-1:1]};
          o_link_enable[k] <= (serving == LINK_IDX);
        end else if (shift) begin
          o_data_bits[k] <= sh_q[0];
          sh_q <= {1'b0, sh_q[WW-1:1]};
        end
      end
    end
  endgenerate

endmodule // mlpr_readout
`default_nettype wire

// File: mlpr_readout_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mlpr_readout_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_bit_strobe,
  input wire logic o_rd_valid,
  input wire logic [2:0] o_rd_burst,
  input wire logic [6:0] o_rd_index,
  input wire logic [11:0] o_rd_row,
  input wire logic [15:0] o_link_enable,
  input wire logic [15:0] o_data_bits,
  input wire logic o_ctrl_bit,
  input wire logic o_forwarded_ddr_clock
);
  // ----------------------------------
  // port relations of the readout
  // ----------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_clk_fall; $fell(o_forwarded_ddr_clock) |-> $past(i_bit_strobe); endproperty
  a_clk_fall: assert property (p_clk_fall) else $error("clock fell without strobe");
  property p_lockstep;
    (!$stable(o_data_bits) || !$stable(o_ctrl_bit)) |-> !$stable(o_forwarded_ddr_clock);
  endproperty
  a_lockstep: assert property (p_lockstep) else $error("bit moved without clock edge");
  property p_idx_step;
    o_rd_valid && $past(o_rd_valid) && $changed(o_rd_index) |->
      o_rd_index == $past(o_rd_index) + 7'h01;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("pixel index skipped");
  property p_first; $rose(o_rd_valid) |-> o_rd_index == 7'h00; endproperty
  a_first: assert property (p_first) else $error("burst not at pixel zero");
  property p_last; $fell(o_rd_valid) |-> $past(o_rd_index) == 7'h7f; endproperty
  a_last: assert property (p_last) else $error("burst not 128 pixels");
  property p_burst_hold; o_rd_valid && $past(o_rd_valid) |-> $stable(o_rd_burst); endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("burst moved in burst");
  property p_row_hold; o_rd_valid && $past(o_rd_valid) |-> $stable(o_rd_row); endproperty
  a_row_hold: assert property (p_row_hold) else $error("row moved in burst");
  property p_links;
    o_link_enable inside {16'hffff, 16'h5555, 16'h1111, 16'h0101};
  endproperty
  a_links: assert property (p_links) else $error("bad link enable set");
endmodule // mlpr_readout_monitor
bind mlpr_readout mlpr_readout_monitor mlpr_readout_monitor_i (.i_sys_clk, .i_rst,
  .i_bit_strobe, .o_rd_valid, .o_rd_burst, .o_rd_index, .o_rd_row, .o_link_enable,
  .o_data_bits, .o_ctrl_bit, .o_forwarded_ddr_clock);
`default_nettype wire

// File: mlpr_deser.sv
`timescale 1ns/1ps
`default_nettype none
module mlpr_deser #(
  parameter int EDGES = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_fclk,
  input wire logic [15:0] i_data,
  input wire logic i_ctrl,
  output logic o_done,
  output logic [11:0] o_w [0:16]
);
  logic fq = 1'b0;
  logic run = 1'b0;
  int n = 0;
  logic [11:0] sh [0:16];
  // one bit per clock edge, word alignment by edge count after the first rise
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_rst) begin
      run = 1'b0;
      n = 0;
    end else if (i_fclk !== fq && (run || i_fclk)) begin
      run = 1'b1;
      for (int k = 0; k < 17; k++) sh[k][n] = k == 16 ? i_ctrl : i_data[k];
      n = n + 1;
      if (n == EDGES) begin
        o_w <= sh;
        o_done <= 1'b1;
        n = 0;
      end
    end
    fq <= i_fclk;
  end
endmodule // mlpr_deser
`default_nettype wire

// File: mlpr_readout_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mlpr_readout_bench;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_pixel_clk = 1'b0, i_bit_strobe = 1'b0;
  logic i_twelve_bit = 1'b0, i_frame_req = 1'b0, v_q = 1'b0;
  logic [1:0] i_mux_sel = 2'h0;
  logic [2:0] gq = 3'h0;
  logic [11:0] i_row_count = 12'h440, i_train_word = 12'h000;
  logic [191:0] i_src_words = '0;
  wire logic o_rd_valid, o_ctrl_bit, o_forwarded_ddr_clock, done;
  wire logic [2:0] o_rd_burst;
  wire logic [6:0] o_rd_index;
  wire logic [11:0] o_rd_row;
  wire logic [15:0] o_link_enable, o_data_bits;
  logic [11:0] w [0:16];
  logic [31:0] snap;
  logic [31:0] miscompares = 0, n_checks = 0, cyc = 0, n_rise, n_hi, n_dv, bmax, rmax, t0, t1;
  mlpr_readout mlpr_readout_i (.i_sys_clk, .i_rst, .i_ce, .i_pixel_clk, .i_bit_strobe,
    .i_twelve_bit, .i_mux_sel, .i_row_count, .i_train_word, .i_frame_req, .i_src_words,
    .o_rd_valid, .o_rd_burst, .o_rd_index, .o_rd_row, .o_link_enable, .o_data_bits,
    .o_ctrl_bit, .o_forwarded_ddr_clock);
  mlpr_deser mlpr_deser_i (.i_clk(i_sys_clk), .i_rst(i_rst), .i_fclk(o_forwarded_ddr_clock),
    .i_data(o_data_bits), .i_ctrl(o_ctrl_bit), .o_done(done), .o_w(w));
  // ----------------------------------
  // clocks, checks and expectations
  // ----------------------------------
  always #12.5 i_sys_clk = ~i_sys_clk;
  // pixel clock at an eighth of the system clock, so only eight bits of each word go out; phase unrelated to the system clock
  initial begin
    #7;
    forever #100 i_pixel_clk = ~i_pixel_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [2:0] grp(input logic [1:0] m, input logic tw);
    grp = (tw && m != 2'h3) ? 3'h3 : (3'h1 << m) - 3'h1;
  endfunction
  function automatic logic [15:0] ens(input logic [2:0] g);
    for (int j = 0; j < 16; j++) ens[j] = (j & g) == 0;
  endfunction
  // expected low byte on data link j: group leader pixel in a burst, else training word
  function automatic logic [11:0] exp_word(input int j, input logic dv);
    exp_word = (dv ? i_src_words[(j & ~gq) * 12 +: 12] : i_train_word) & 12'h0ff;
  endfunction
  // outputs that must stand still while the clock enable is low
  function automatic logic [31:0] outs();
    outs = {3'h0, o_data_bits, o_rd_index, o_rd_burst, o_ctrl_bit, o_forwarded_ddr_clock,
      o_rd_valid};
  endfunction
  // burst statistics and a compare of every received data word and of each pixel control word
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    v_q <= o_rd_valid;
    if (o_rd_valid) n_hi <= n_hi + 1;
    if (o_rd_valid && !v_q) n_rise <= n_rise + 1;
    if (o_rd_valid && !v_q && n_rise == 0) t0 <= cyc;
    if (!o_rd_valid && v_q) t1 <= cyc;
    if (o_rd_valid && o_rd_burst > bmax) bmax <= 32'(o_rd_burst);
    if (o_rd_valid && o_rd_row > rmax) rmax <= 32'(o_rd_row);
    if (done) begin
      if (w[16][0]) n_dv <= n_dv + 1;
      if (w[16][0]) chk(w[16] & 12'h0ff, 32'h0000_0007);
      for (int j = 0; j < 16; j++)
        chk(w[j] & 12'h0ff, exp_word(j, w[16][0]));
    end
    if (i_frame_req) {n_hi, n_rise, n_dv, bmax, rmax} <= '0;
  end
  task automatic frame(input logic [1:0] m, input logic tw);
    logic [31:0] r, g;
    int t;
    @(posedge i_sys_clk);
    i_mux_sel <= m;
    i_twelve_bit <= tw;
    i_row_count <= 12'($urandom_range(2, 1));
    for (int k = 0; k < 192; k += 12) i_src_words[k +: 12] <= 12'($urandom);
    i_frame_req <= 1'b1;
    @(posedge i_sys_clk);
    i_frame_req <= 1'b0;
    gq <= grp(m, tw);
    t = 0;
    while (t < 40) begin
      @(posedge i_sys_clk);
      t = o_rd_valid ? 0 : t + 1;
    end
    r = 32'(i_row_count);
    g = 32'(gq);
    chk(n_rise, r * (g + 1));
    chk(t1 - t0, r * (g + 1) * 1032 - 8);
    chk(n_hi, r * (g + 1) * 1024);
    chk(n_dv, r * (g + 1) * 128);
    chk(bmax, g);
    chk(rmax, r - 1);
    chk(o_link_enable, ens(gq));
    $display("frame test mux %0d twelve %0d done", m, tw);
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, with margin over the longest expected run
  initial begin
    #2_000_000;
    miscompares = miscompares + 1;
    print_verdict;
  end
  // reset, every multiplex mode at ten bits, the eight- and two-link selects at twelve, then a reset mid frame
  initial begin
    void'($urandom(32'heb3e_53b5));
    i_train_word = 12'($urandom);
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    i_bit_strobe <= 1'b1;
    chk(o_link_enable, 32'h0000_ffff);
    for (int m = 0; m < 4; m++) frame(2'(m), 1'b0);
    frame(2'h1, 1'b1);
    frame(2'h3, 1'b1);
    frame(2'h0, 1'b0);
    // freeze mid burst, reset while frozen, then recover with one more frame
    @(posedge i_sys_clk);
    i_frame_req <= 1'b1;
    @(posedge i_sys_clk);
    i_frame_req <= 1'b0;
    wait (o_rd_valid);
    repeat (300) @(posedge i_sys_clk);
    i_ce <= 1'b0;
    @(posedge i_sys_clk);
    snap = outs();
    repeat (20) @(posedge i_sys_clk);
    chk(outs(), snap);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    chk(32'(o_rd_valid), 32'h0000_0000);
    chk(o_link_enable, 32'h0000_ffff);
    chk({o_data_bits, o_ctrl_bit, o_forwarded_ddr_clock}, 32'h0000_0000);
    i_ce <= 1'b1;
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    chk(o_link_enable, 32'h0000_ffff);
    chk({o_data_bits, o_ctrl_bit, o_forwarded_ddr_clock}, 32'h0000_0000);
    $display("reset test done");
    frame(2'h0, 1'b0);
    print_verdict;
  end
endmodule // mlpr_readout_bench
`default_nettype wire
